// ===== ask_sync_pkg.sv
// constants, types and register map of the ask data sync and debounce block
// Behaviour
// - raw demodulator input is resampled on the extended tick only
// - spacing of output edges while receiving is a whole number of extended ticks
// - base tick is crystal clock divided by 10 (mode low) or 14 (high)
// - extended tick is 8, 4, 2 or 1 base ticks for ranges 0 to 3
// - while receiving, output edges never closer than 10 extended ticks; spikes that end inside that gap dropped
// - start-up lasts 896.5, 512.5, 512.5 or 320.5 base ticks per range
// - baud pins 00, 01, 1x decode to ranges 0, 1, 2
// - enable low means sleep: processing stopped, input ignored
// - receiving routes data out, stream starts on a falling edge
package ask_sync_pkg;

  // base tick dividers in clk cycles, per mode pin level
  localparam int DIV_MODE_LOW = 10;
  localparam int DIV_MODE_HIGH = 14;

  // extended tick length in base ticks, per baud range
  localparam int EXT_LEN_R0 = 8;
  localparam int EXT_LEN_R1 = 4;
  localparam int EXT_LEN_R2 = 2;
  localparam int EXT_LEN_R3 = 1;

  // start-up length in half base ticks (896.5, 512.5, 512.5, 320.5 ticks)
  localparam int STARTUP_HALF_R0 = 1793;
  localparam int STARTUP_HALF_R1 = 1025;
  localparam int STARTUP_HALF_R2 = 1025;
  localparam int STARTUP_HALF_R3 = 641;

  // least spacing of output edges in extended ticks
  localparam int MIN_EDGE_TICKS = 10;

  // idle level of the data output outside receiving
  localparam logic DATA_IDLE = 1'b1;

  // apb register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // ctrl fields: bit0 run gate, bit1 range override, bits3:2 range
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_OVR_BIT = 1;
  localparam int CTRL_RANGE_LSB = 2;
  localparam logic [3:0] CTRL_RESET = 4'h1;

  typedef enum logic [1:0] {
    SLEEP,
    STARTUP,
    RECEIVING
  } rx_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

// ===== ask_data_sync_debounce.sv
// ask receiver back end: tick dividers, enable sequencing, sync and debounce
module ask_data_sync_debounce
  import ask_sync_pkg::*;
#(
  parameter int STARTUP_R0 = STARTUP_HALF_R0,
  parameter int STARTUP_R1 = STARTUP_HALF_R1,
  parameter int STARTUP_R2 = STARTUP_HALF_R2,
  parameter int STARTUP_R3 = STARTUP_HALF_R3,
  parameter int EDGE_GAP = MIN_EDGE_TICKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic modeSel,
  input wire logic baudSelLsb,
  input wire logic baudSelMsb,
  input wire logic enable,
  input wire logic demodIn,
  input wire apb_req_t apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic dataOut
);

  // refuse settings the counters cannot hold
  if (EDGE_GAP < 1 || EDGE_GAP > 255) begin : g_bad_gap
    $error("edge gap out of range");
  end
  if (STARTUP_R0 < 1 || STARTUP_R0 > 4095 || STARTUP_R1 < 1 ||
      STARTUP_R1 > 4095 || STARTUP_R2 < 1 || STARTUP_R2 > 4095 ||
      STARTUP_R3 < 1 || STARTUP_R3 > 4095) begin : g_bad_startup
    $error("start-up length out of range");
  end

  // baud pins to range, 1x both give range 2
  function automatic logic [1:0] decodeRange(input logic msb,
                                             input logic lsb);
    decodeRange = msb ? 2'd2 : {1'b0, lsb};
  endfunction

  // extended tick length in base ticks
  function automatic logic [3:0] extLenOf(input logic [1:0] r);
    case (r)
      2'd0: extLenOf = 4'(EXT_LEN_R0);
      2'd1: extLenOf = 4'(EXT_LEN_R1);
      2'd2: extLenOf = 4'(EXT_LEN_R2);
      default: extLenOf = 4'(EXT_LEN_R3);
    endcase
  endfunction

  rx_state_t state_reg, state_next;
  logic [3:0] ctrl_reg;
  logic [2:0] divCnt_reg;
  logic phase_reg;
  logic [11:0] halfCnt_reg;
  logic [3:0] extCnt_reg;
  logic lastSample_reg;
  logic streaming_reg;
  logic [7:0] gapCnt_reg;
  logic dataOut_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;

  // configuration selection
  wire runEnable = enable & ctrl_reg[CTRL_RUN_BIT];
  wire [1:0] activeRange = ctrl_reg[CTRL_OVR_BIT] ?
    ctrl_reg[CTRL_RANGE_LSB +: 2] : decodeRange(baudSelMsb, baudSelLsb);
  wire [2:0] halfLen = modeSel ? 3'(DIV_MODE_HIGH / 2) :
    3'(DIV_MODE_LOW / 2);
  wire [3:0] extLen = extLenOf(activeRange);
  wire [11:0] startupLen = (activeRange == 2'd0) ? 12'(STARTUP_R0) :
    (activeRange == 2'd1) ? 12'(STARTUP_R1) :
    (activeRange == 2'd2) ? 12'(STARTUP_R2) : 12'(STARTUP_R3);

  // tick generation; nothing runs in sleep
  wire active = state_reg != SLEEP;
  wire halfTick = active && divCnt_reg == halfLen - 3'd1;
  wire baseTick = halfTick && phase_reg && state_reg == RECEIVING;
  wire extTick = baseTick && extCnt_reg == extLen - 4'd1;
  wire startupDone = halfTick && halfCnt_reg == startupLen - 12'd1;

  // debounce decision on each extended tick
  wire fallSeen = extTick && lastSample_reg && !demodIn;
  wire gapOk = gapCnt_reg >= 8'(EDGE_GAP - 1);
  wire streamOn = streaming_reg || fallSeen;
  wire takeEdge = extTick && streamOn && demodIn != dataOut_reg && gapOk;

  // state sequencing from enable
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SLEEP: if (runEnable) state_next = STARTUP;
      STARTUP: begin
        if (!runEnable) state_next = SLEEP;
        else if (startupDone) state_next = RECEIVING;
      end
      RECEIVING: if (!runEnable) state_next = SLEEP;
      default: state_next = SLEEP;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) state_reg <= SLEEP;
    else state_reg <= state_next;
  end

  // half base tick divider and phase of the base tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divCnt_reg <= 3'd0;
      phase_reg <= 1'b0;
    end else if (!active || state_next == SLEEP) begin
      divCnt_reg <= 3'd0;
      phase_reg <= 1'b0;
    end else if (halfTick) begin
      divCnt_reg <= 3'd0;
      phase_reg <= state_reg == RECEIVING && !phase_reg;
    end else begin
      divCnt_reg <= divCnt_reg + 3'd1;
    end
  end

  // start-up length counter in half base ticks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) halfCnt_reg <= 12'd0;
    else if (state_reg != STARTUP) halfCnt_reg <= 12'd0;
    else if (halfTick) halfCnt_reg <= halfCnt_reg + 12'd1;
  end

  // extended tick counter in base ticks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) extCnt_reg <= 4'd0;
    else if (state_reg != RECEIVING || extTick) extCnt_reg <= 4'd0;
    else if (baseTick) extCnt_reg <= extCnt_reg + 4'd1;
  end

  // resampling, stream arming and edge spacing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lastSample_reg <= 1'b0;
      streaming_reg <= 1'b0;
      gapCnt_reg <= 8'd0;
    end else if (state_reg != RECEIVING) begin
      lastSample_reg <= 1'b0;
      streaming_reg <= 1'b0;
      gapCnt_reg <= 8'd0;
    end else if (extTick) begin
      lastSample_reg <= demodIn;
      streaming_reg <= streamOn;
      if (takeEdge) gapCnt_reg <= 8'd0;
      else if (!gapOk) gapCnt_reg <= gapCnt_reg + 8'd1;
    end
  end

  // data output, changes on an extended tick while receiving, forced to the idle level outside receiving
  always_ff @(posedge clk or posedge rst) begin
    if (rst) dataOut_reg <= DATA_IDLE;
    else if (state_reg != RECEIVING) dataOut_reg <= DATA_IDLE;
    else if (takeEdge) dataOut_reg <= demodIn;
  end

  // apb decode: one wait state, write lands on the pready edge
  wire setupDone = apbReq.psel && apbReq.penable && !pready_reg;
  wire apbWrite = apbReq.psel && apbReq.penable && pready_reg &&
    apbReq.pwrite;
  wire hitCtrl = apbReq.paddr == CTRL_OFFSET;
  wire hitStatus = apbReq.paddr == STATUS_OFFSET;
  wire [31:0] statusWord = {25'h0, streaming_reg, activeRange,
    dataOut_reg, 2'(state_reg), modeSel};
  wire [31:0] readWord = hitCtrl ? {28'h0, ctrl_reg} :
    hitStatus ? statusWord : 32'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= setupDone;
      pslverr_reg <= setupDone && !hitCtrl && !hitStatus;
      prdata_reg <= (setupDone && !apbReq.pwrite) ? readWord : 32'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) ctrl_reg <= CTRL_RESET;
    else if (apbWrite && hitCtrl) ctrl_reg <= apbReq.pwdata[3:0];
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign dataOut = dataOut_reg;

  // helper counters for the checks below
  logic prevOut_h, spanOk_h, baseSeen_h, prevMode_h;
  logic [1:0] prevRange_h;
  logic [15:0] clkSince_h, stClks_h;
  logic [7:0] tickSince_h;
  logic [4:0] clkSinceBase_h;
  wire outChanged = dataOut_reg != prevOut_h;
  wire cfgSame = modeSel == prevMode_h && activeRange == prevRange_h;
  wire [15:0] extClks = 16'(extLen) * 16'(halfLen) * 16'd2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prevOut_h <= DATA_IDLE;
      spanOk_h <= 1'b0;
      baseSeen_h <= 1'b0;
      prevMode_h <= 1'b0;
      prevRange_h <= 2'd0;
      clkSince_h <= 16'd0;
      stClks_h <= 16'd0;
      tickSince_h <= 8'd0;
      clkSinceBase_h <= 5'd0;
    end else begin
      prevOut_h <= dataOut_reg;
      prevMode_h <= modeSel;
      prevRange_h <= activeRange;
      clkSince_h <= outChanged ? 16'd1 : clkSince_h + 16'd1;
      tickSince_h <= outChanged ? 8'(extTick) : tickSince_h + 8'(extTick);
      spanOk_h <= outChanged ? state_reg == RECEIVING :
        spanOk_h && cfgSame && state_reg == RECEIVING &&
        tickSince_h != 8'hFF; // long spans leave the span checks
      clkSinceBase_h <= baseTick ? 5'd1 : clkSinceBase_h + 5'd1;
      baseSeen_h <= baseTick ? cfgSame : baseSeen_h && cfgSame &&
        state_reg == RECEIVING;
      stClks_h <= (state_reg == STARTUP && cfgSame) ? stClks_h + 16'd1 :
        16'd0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence enterRx;
    (state_reg == STARTUP) ##1 (state_reg == RECEIVING);
  endsequence

  a_data_on_tick: assert property (
    $changed(dataOut) && $past(state_reg == RECEIVING) |-> $past(extTick))
    else $error("data changed off the extended tick");
  a_span_whole: assert property (
    outChanged && spanOk_h |-> clkSince_h == 16'(tickSince_h) * extClks)
    else $error("edge span not whole extended ticks");
  a_base_divider: assert property (
    baseTick && baseSeen_h |->
    clkSinceBase_h == (modeSel ? 5'(DIV_MODE_HIGH) : 5'(DIV_MODE_LOW)))
    else $error("base tick period wrong");
  a_ext_range3: assert property (
    baseTick && activeRange == 2'd3 |-> extTick)
    else $error("range 3 extended tick not every base tick");
  a_edge_gap: assert property (
    outChanged && spanOk_h |-> tickSince_h >= 8'(EDGE_GAP))
    else $error("data edges too close");
  a_startup_len: assert property (
    enterRx |-> $past(stClks_h) + 16'd1 ==
    16'(startupLen) * 16'(halfLen))
    else $error("start-up length wrong");
  a_range_pins: assert property (
    !ctrl_reg[CTRL_OVR_BIT] && baudSelMsb |-> extLen == 4'd2)
    else $error("baud pins 1x not range 2");
  a_sleep_quiet: assert property (
    !runEnable |=> state_reg == SLEEP ##1 (!halfTick && dataOut))
    else $error("sleep not entered or not quiet");
  a_stream_start: assert property (
    $fell(dataOut) && !$past(streaming_reg) |-> $past(fallSeen))
    else $error("stream did not start on a falling edge");
  a_idle_clear: assert property (
    state_reg != RECEIVING |=> gapCnt_reg == 8'd0 ||
    state_reg == RECEIVING)
    else $error("spacing counter not cleared");

endmodule

// ===== mcu_edge_probe.sv
// microcontroller side model: times the gaps between edges on the data pin
module mcu_edge_probe (
  input wire logic clk,
  input wire logic rst,
  input wire logic dataPin,
  output logic [31:0] lastGap,
  output logic [31:0] edgeCount
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prevLevel;
  logic [31:0] runLen;
  wire logic edgeSeen = dataPin != prevLevel;
  // count cycles since the last edge, latch the gap at each edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prevLevel <= 1'b1;
      runLen <= 32'h0;
      lastGap <= 32'h0;
      edgeCount <= 32'h0;
    end else begin
      prevLevel <= dataPin;
      runLen <= edgeSeen ? 32'h1 : runLen + 32'h1;
      if (edgeSeen) begin
        lastGap <= runLen;
        edgeCount <= edgeCount + 32'h1;
      end
    end
  end
endmodule

// ===== ask_data_sync_debounce_tb_top.sv
// self-checking bench: pin sequencing, apb registers, resampling, debounce
module ask_data_sync_debounce_tb_top;
  import ask_sync_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SU = 4;
  logic clk = 1'b0, rst = 1'b1, modeSel = 1'b0, baudSelLsb = 1'b0;
  logic baudSelMsb = 1'b0, enable = 1'b0, demodIn = 1'b1, pready, pslverr;
  logic dataOut;
  apb_req_t apbReq = '0;
  logic [31:0] prdata, lastGap, edgeCount, rd, seed = 32'h4EC306A7;
  logic err;
  int n_mismatch = 0, total_checks = 0, ext, half, base, k;
  int extLen[4] = '{8, 4, 2, 1};
  ask_data_sync_debounce #(.STARTUP_R0(SU), .STARTUP_R1(SU),
    .STARTUP_R2(SU), .STARTUP_R3(SU)) ask_data_sync_debounce_inst (
    .clk(clk), .rst(rst), .modeSel(modeSel), .baudSelLsb(baudSelLsb),
    .baudSelMsb(baudSelMsb), .enable(enable), .demodIn(demodIn),
    .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dataOut(dataOut));
  mcu_edge_probe mcu_edge_probe_inst (.clk(clk), .rst(rst),
    .dataPin(dataOut), .lastGap(lastGap), .edgeCount(edgeCount));
  always #50 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one apb transfer: setup, access, hold until pready sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    apbReq <= '0;
    if (n >= 50) chk("pready", 32'h0, 32'h1);
  endtask
  // wait for dataOut to reach a level within a bound
  task automatic waitData(input logic v, input int lim);
    int n;
    n = 0;
    while (dataOut !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("dataOut level", {31'h0, dataOut}, {31'h0, v});
  endtask
  initial begin
    #5000000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    chk("dataOut reset", {31'h0, dataOut}, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl reset", rd, 32'h1);
    for (int r = 0; r < 4; r++) begin
      seed = lfsr(seed);
      @(posedge clk);
      enable <= 1'b0;
      modeSel <= seed[0];
      baudSelMsb <= (r >= 2);
      baudSelLsb <= (r == 1) | ((r >= 2) & seed[1]);
      base = seed[0] ? DIV_MODE_HIGH : DIV_MODE_LOW;
      half = base / 2;
      ext = base * extLen[r];
      apb(1'b1, CTRL_OFFSET, (r == 3) ? 32'hF : 32'h1);
      k = edgeCount;
      // sleep: input toggles must not reach the pin
      repeat (20) begin
        @(posedge clk);
        demodIn <= ~demodIn;
      end
      @(posedge clk);
      demodIn <= 1'b1;
      chk("sleep data", {31'h0, dataOut}, 32'h1);
      chk("sleep edges", edgeCount, k);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk("range", {30'h0, rd[5:4]}, r);
      chk("mode", {31'h0, rd[0]}, {31'h0, seed[0]});
      chk("sleep state", {30'h0, rd[2:1]}, 32'h0);
      @(posedge clk);
      enable <= 1'b1;
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk("startup state", {30'h0, rd[2:1]}, 32'h1);
      repeat (SU * half - 8) @(posedge clk);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk("late startup", {30'h0, rd[2:1]}, 32'h1);
      chk("startup data", {31'h0, dataOut}, 32'h1);
      repeat (8) @(posedge clk);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk("receiving", {30'h0, rd[2:1]}, 32'h2);
      // a high sample must come first so that the fall is seen
      repeat (2 * ext) @(posedge clk);
      demodIn <= 1'b0;
      waitData(1'b0, 12 * ext);
      demodIn <= 1'b1;
      waitData(1'b1, 12 * ext);
      @(posedge clk); // let the probe latch the gap
      chk("min gap", lastGap, 10 * ext);
      chk("gap whole", lastGap % ext, 32'h0);
      k = edgeCount;
      seed = lfsr(seed);
      demodIn <= 1'b0;
      repeat ((seed[1:0] + 1) * ext) @(posedge clk);
      demodIn <= 1'b1;
      repeat (12 * ext) @(posedge clk);
      chk("spike dropped", edgeCount, k);
      enable <= 1'b0;
      repeat (3) @(posedge clk);
      chk("back asleep", {31'h0, dataOut}, 32'h1);
    end
    tally_and_finish();
  end
endmodule
